// ### pkg/ssf_pkg.sv
// Register map, field positions and reset values of the serial status block
package ssf_pkg;

   // Register byte offsets on the APB port
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_TX_DATA  = 8'h08;
   localparam logic [7:0] OFS_RX_DATA  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   // Serial status register fields
   localparam int BIT_TX_EMPTY  = 7;
   localparam int BIT_RX_FULL   = 6;
   localparam int BIT_OVERRUN   = 5;
   localparam int BIT_FRAME_ERR = 4;
   localparam int BIT_PARITY    = 3;
   localparam int BIT_TX_END    = 2;

   // Serial control register fields
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_RX_ENABLE = 4;

   // Reset values
   localparam logic [7:0] STATUS_RESET  = 8'h84;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET     = 8'h00;

   // Writable bits of the control and interrupt registers
   localparam logic [7:0] CONTROL_WMASK = 8'h30;
   localparam logic [7:0] IRQ_WMASK     = 8'hf8;

   // Number of software-clearable flags and their lowest position
   localparam int NUM_FLAGS = 5;
   localparam int FLAG_LSB  = 3;

endpackage : ssf_pkg

// ### design/ssf_clr_flag.sv
// One status flag that software may only clear, and only after reading a one
module ssf_clr_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Low-power reload to the reset value
   input  wire logic reload,
   // Hardware set and clear
   input  wire logic set_ev,
   input  wire logic hw_clr,
   // Software access
   input  wire logic seen_one,
   input  wire logic wr_status,
   input  wire logic wr_bit,
   // Flag
   output logic      flag
);

   logic armed;

   // Armed once software has read this flag as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed <= 1'b0;
      end else if (reload || wr_status) begin
         armed <= 1'b0;
      end else if (seen_one) begin
         armed <= 1'b1;
      end else if (!flag) begin
         armed <= 1'b0; // A hardware clear voids the earlier read
      end
   end

   // Reload wins over all; set wins over any other clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= RESET_VAL;
      end else if (reload) begin
         flag <= RESET_VAL;
      end else if (set_ev) begin
         flag <= 1'b1;
      end else if (hw_clr) begin
         flag <= 1'b0;
      end else if (wr_status && !wr_bit && armed) begin
         flag <= 1'b0; // Writing one, or zero unread, does nothing
      end
   end

endmodule : ssf_clr_flag

// ### design/ssf_serial_status.sv
// Serial status flags with control, data and interrupt registers over APB
//
// What this block does
// - Status loads 0x84 on reset and standby
// - Flags: tx empty 7, rx full 6, overrun 5
// - Software writing one never sets a flag
// - Writing zero after reading one clears flag
// - Tx empty forced high while tx disabled
// - Tx empty sets when holding moves out
// - Writing transmit byte clears tx empty
// - Good reception loads holding, sets rx full
// - Reading receive holding clears rx full
// - Errors or rx disabled leave holding alone
// - Reception while full flags overrun, drops byte
// - Overrun detection sets the overrun flag
// - Overrun suspends reception; sync mode also transmission
// - Overrun keeps old byte, loses new one
// - Disabling receiver leaves receive flags unchanged
//
// Design decisions made here: the APB slave port and the placing of the registers.
module ssf_serial_status #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Low-power mode entry, level from the power controller
   input  wire logic              standby,
   // Mode select: high for clocked synchronous operation
   input  wire logic              sync_mode,
   // Transmit shift engine
   output logic [DATA_W-1:0]      tx_data,
   output logic                   tx_valid,
   input  wire logic              tx_take,
   input  wire logic              tx_shift_idle,
   // Receive shift engine
   input  wire logic              rx_done,
   input  wire logic [DATA_W-1:0] rx_data,
   input  wire logic              rx_frame_err,
   input  wire logic              rx_parity_err,
   output logic                   rx_suspend,
   // Interrupt
   output logic                   irq
);

   // Flag count sets the width of the flag vector below
   localparam int NUM_FLAG_C = ssf_pkg::NUM_FLAGS;

   // Register state and assembled status
   logic [7:0]        control;
   logic [7:0]        irq_stat;
   logic [7:0]        irq_mask;
   logic [DATA_W-1:0] rx_hold;
   logic              tx_end;
   logic [7:0]        status;
   logic [7:0]        rd_seen;

   // Bus phases and decode
   logic              setup;
   logic              access;
   logic              wr_now;
   logic              rd_now;
   logic              hit;

   // Enables and receive qualifiers
   logic              tx_en;
   logic              rx_en;
   logic              rx_live;
   logic              rx_bad;
   logic              rx_good;
   logic              overrun_ev;
   logic              rx_load;

   // Strobes, events, read data and flag cells
   logic              wr_stat;
   logic              tx_write;
   logic              rx_read;
   logic [7:0]        ev_vec;
   logic [7:0]        next_prdata;
   logic [NUM_FLAG_C-1:0] flags;

   // Address decode shared by read and write strobes and error answer
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ssf_pkg::OFS_STATUS)   || (a == ssf_pkg::OFS_CONTROL) ||
               (a == ssf_pkg::OFS_TX_DATA)  || (a == ssf_pkg::OFS_RX_DATA) ||
               (a == ssf_pkg::OFS_IRQ_STAT) || (a == ssf_pkg::OFS_IRQ_MASK);
   endfunction : mapped

   // Masked register update for software writes
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic [7:0] wm);
      merge = (old & ~wm) | (wd & wm);
   endfunction : merge

   // APB phases; the slave never waits, so every access is one cycle
   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign hit      = mapped(paddr);
   assign wr_now   = access && pwrite && hit;
   assign rd_now   = access && !pwrite && hit;
   assign pready   = 1'b1;
   assign pslverr  = access && !hit;

   // Register strobes
   assign wr_stat  = wr_now && (paddr == ssf_pkg::OFS_STATUS);
   assign tx_write = wr_now && (paddr == ssf_pkg::OFS_TX_DATA) && tx_en;
   assign rx_read  = rd_now && (paddr == ssf_pkg::OFS_RX_DATA);

   // Enable bits; clearing tx enable also forces tx empty high
   assign tx_en = control[ssf_pkg::BIT_TX_ENABLE];
   assign rx_en = control[ssf_pkg::BIT_RX_ENABLE];

   // Reception gating; flags and data hold while the receiver is off
   assign rx_live    = rx_done && rx_en && !rx_suspend;
   assign rx_bad     = rx_frame_err || rx_parity_err;
   assign rx_good    = rx_live && !rx_bad;
   assign overrun_ev = rx_good && status[ssf_pkg::BIT_RX_FULL];
   assign rx_load    = rx_good && !status[ssf_pkg::BIT_RX_FULL];

   // Overrun and framing errors stall reception until software clears them
   assign rx_suspend =
      flags[ssf_pkg::BIT_OVERRUN - ssf_pkg::FLAG_LSB] ||
      flags[ssf_pkg::BIT_FRAME_ERR - ssf_pkg::FLAG_LSB];

   // Transmit offer; in synchronous mode an overrun also stops sending
   assign tx_valid = tx_en && !status[ssf_pkg::BIT_TX_EMPTY] &&
                     !(sync_mode && rx_suspend);

   // Control register, cleared by low-power entry as well
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= ssf_pkg::CONTROL_RESET;
      end else if (standby) begin
         control <= ssf_pkg::CONTROL_RESET;
      end else if (wr_now && (paddr == ssf_pkg::OFS_CONTROL)) begin
         control <= merge(control, pwdata[7:0], ssf_pkg::CONTROL_WMASK);
      end
   end

   // Transmit holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data <= '0;
      end else if (tx_write) begin
         tx_data <= pwdata[DATA_W-1:0];
      end
   end

   // Receive holding keeps the older byte on overrun or error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hold <= '0;
      end else if (rx_load) begin
         rx_hold <= rx_data;
      end
   end

   // Which flags software last saw as one, from the data it was given
   assign rd_seen = (rd_now && (paddr == ssf_pkg::OFS_STATUS)) ?
                    prdata[7:0] : 8'h00;

   // Flag cells: transmit empty, receive full, overrun, framing, parity
   ssf_clr_flag #(.RESET_VAL(ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_EMPTY]))
   u_tx_empty (
      .pclk      (pclk),
      .presetn   (presetn),
      .reload    (standby),
      .set_ev    (tx_take || !tx_en),
      .hw_clr    (tx_write),
      .seen_one  (rd_seen[ssf_pkg::BIT_TX_EMPTY]),
      .wr_status (wr_stat),
      .wr_bit    (pwdata[ssf_pkg::BIT_TX_EMPTY]),
      .flag      (flags[ssf_pkg::BIT_TX_EMPTY - ssf_pkg::FLAG_LSB])
   );

   // Receive full; a read of the holding byte clears it
   ssf_clr_flag #(.RESET_VAL(ssf_pkg::STATUS_RESET[ssf_pkg::BIT_RX_FULL]))
   u_rx_full (
      .pclk      (pclk),
      .presetn   (presetn),
      .reload    (standby),
      .set_ev    (rx_load),
      .hw_clr    (rx_read),
      .seen_one  (rd_seen[ssf_pkg::BIT_RX_FULL]),
      .wr_status (wr_stat),
      .wr_bit    (pwdata[ssf_pkg::BIT_RX_FULL]),
      .flag      (flags[ssf_pkg::BIT_RX_FULL - ssf_pkg::FLAG_LSB])
   );

   // Overrun has no hardware clear; only software or standby drops it
   ssf_clr_flag #(.RESET_VAL(ssf_pkg::STATUS_RESET[ssf_pkg::BIT_OVERRUN]))
   u_overrun (
      .pclk      (pclk),
      .presetn   (presetn),
      .reload    (standby),
      .set_ev    (overrun_ev),
      .hw_clr    (1'b0),
      .seen_one  (rd_seen[ssf_pkg::BIT_OVERRUN]),
      .wr_status (wr_stat),
      .wr_bit    (pwdata[ssf_pkg::BIT_OVERRUN]),
      .flag      (flags[ssf_pkg::BIT_OVERRUN - ssf_pkg::FLAG_LSB])
   );

   ssf_clr_flag #(.RESET_VAL(ssf_pkg::STATUS_RESET[ssf_pkg::BIT_FRAME_ERR]))
   u_frame_err (
      .pclk      (pclk),
      .presetn   (presetn),
      .reload    (standby),
      .set_ev    (rx_live && rx_frame_err),
      .hw_clr    (1'b0),
      .seen_one  (rd_seen[ssf_pkg::BIT_FRAME_ERR]),
      .wr_status (wr_stat),
      .wr_bit    (pwdata[ssf_pkg::BIT_FRAME_ERR]),
      .flag      (flags[ssf_pkg::BIT_FRAME_ERR - ssf_pkg::FLAG_LSB])
   );

   ssf_clr_flag #(.RESET_VAL(ssf_pkg::STATUS_RESET[ssf_pkg::BIT_PARITY]))
   u_parity (
      .pclk      (pclk),
      .presetn   (presetn),
      .reload    (standby),
      .set_ev    (rx_live && rx_parity_err),
      .hw_clr    (1'b0),
      .seen_one  (rd_seen[ssf_pkg::BIT_PARITY]),
      .wr_status (wr_stat),
      .wr_bit    (pwdata[ssf_pkg::BIT_PARITY]),
      .flag      (flags[ssf_pkg::BIT_PARITY - ssf_pkg::FLAG_LSB])
   );

   // Transmit end: holding empty and shifter idle, one cycle behind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_end <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_END];
      end else if (standby) begin
         tx_end <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_END];
      end else begin
         tx_end <= status[ssf_pkg::BIT_TX_EMPTY] && tx_shift_idle;
      end
   end

   // Assembled status byte, low two bits read as zero
   assign status = {flags[NUM_FLAG_C-1:0], tx_end, 2'b00};

   // Interrupt events share the status layout
   assign ev_vec = {tx_take || tx_write, rx_load, overrun_ev,
                    rx_live && rx_frame_err, rx_live && rx_parity_err,
                    3'b000};

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= ssf_pkg::IRQ_RESET;
      end else if (wr_now && (paddr == ssf_pkg::OFS_IRQ_STAT)) begin
         irq_stat <= (irq_stat & ~(pwdata[7:0] & ssf_pkg::IRQ_WMASK)) |
                     ev_vec;
      end else begin
         irq_stat <= irq_stat | ev_vec;
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= ssf_pkg::IRQ_RESET;
      end else if (wr_now && (paddr == ssf_pkg::OFS_IRQ_MASK)) begin
         irq_mask <= merge(irq_mask, pwdata[7:0], ssf_pkg::IRQ_WMASK);
      end
   end

   // Level output; stays high until every unmasked bit is cleared
   assign irq = |(irq_stat & irq_mask);

   // Read mux, evaluated in the setup cycle
   always_comb begin
      next_prdata = 8'h00;
      case (paddr)
         ssf_pkg::OFS_STATUS:   next_prdata = status;
         ssf_pkg::OFS_CONTROL:  next_prdata = control;
         ssf_pkg::OFS_TX_DATA:  next_prdata = 8'(tx_data);
         ssf_pkg::OFS_RX_DATA:  next_prdata = 8'(rx_hold);
         ssf_pkg::OFS_IRQ_STAT: next_prdata = irq_stat;
         ssf_pkg::OFS_IRQ_MASK: next_prdata = irq_mask;
         default:               next_prdata = 8'h00;
      endcase
   end

   // Read data captured at setup so it is a flop in the access phase;
   // side effects of the read then act on exactly the value returned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= {24'h00_0000, next_prdata};
      end
   end

endmodule : ssf_serial_status

// ### verif/ssf_serial_monitor.sv
// Port-level checker of the serial status block
module ssf_serial_monitor #(
   parameter int DATA_W = 8
) (
   // Clock, reset and APB
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // Modes and shift engines
   input wire logic              standby,
   input wire logic              sync_mode,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic              tx_valid,
   input wire logic              tx_take,
   input wire logic              tx_shift_idle,
   input wire logic              rx_done,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic              rx_frame_err,
   input wire logic              rx_parity_err,
   input wire logic              rx_suspend,
   input wire logic              irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decoded write strobes
   logic wr_any;
   logic wr_st;
   logic wr_tx;
   assign wr_any = psel && penable && pwrite;
   assign wr_st  = wr_any && paddr == ssf_pkg::OFS_STATUS;
   assign wr_tx  = wr_any && paddr == ssf_pkg::OFS_TX_DATA;
   // Setup cycle of a status read
   sequence s_stat_rd;
      psel && !penable && !pwrite && paddr == ssf_pkg::OFS_STATUS;
   endsequence
   status_fmt_a: assert property (s_stat_rd |=>
      prdata[31:8] == 24'h0 && prdata[1:0] == 2'b00)
      else $error("status read has stray bits");
   reload_a: assert property (standby |=> !tx_valid && !rx_suspend)
      else $error("standby did not reload");
   no_set_a: assert property (wr_st && !rx_suspend && !rx_done
      |=> !rx_suspend) else $error("status write set a flag");
   tx_off_a: assert property (wr_any && paddr == ssf_pkg::OFS_CONTROL
      && !pwdata[ssf_pkg::BIT_TX_ENABLE] |=> !tx_valid)
      else $error("transmit still offered while disabled");
   take_empty_a: assert property (tx_valid && tx_take && !wr_tx
      |=> !tx_valid) else $error("holding not emptied by take");
   tx_hold_a: assert property (!wr_tx |=> $stable(tx_data))
      else $error("holding byte changed without write");
   suspend_hold_a: assert property (rx_suspend && !wr_any && !standby
      |=> rx_suspend) else $error("suspend dropped by itself");
   sync_block_a: assert property (sync_mode && rx_suspend
      |-> !tx_valid) else $error("sync transmit not suspended");
endmodule : ssf_serial_monitor

bind ssf_serial_status ssf_serial_monitor #(.DATA_W(DATA_W)) u_mon (.*);

// ### verif/ssf_shift_model.sv
// Behavioural shift engines facing the serial status block
module ssf_shift_model (
   // Clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // Transmit engine
   input wire logic [7:0] tx_data,
   input wire logic   tx_valid,
   output logic       tx_take,
   output logic       tx_shift_idle,
   // Receive engine
   output logic       rx_done,
   output logic [7:0] rx_data,
   output logic       rx_frame_err,
   output logic       rx_parity_err
);
   timeunit 1ns;
   timeprecision 1ns;
   int lat = 4;
   int cnt = 0;
   logic [7:0] sent[$];
   initial {rx_done, rx_data, rx_frame_err, rx_parity_err} = 11'h0;
   assign tx_shift_idle = !tx_take;
   // Takes an offered byte only after lat cycles, so the bench can stall it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_take <= 1'b0;
         cnt <= 0;
      end else begin
         tx_take <= tx_valid && !tx_take && cnt >= lat;
         cnt <= (tx_valid && !tx_take && cnt < lat) ? cnt + 1 : 0;
         if (tx_valid && !tx_take && cnt >= lat) sent.push_back(tx_data);
      end
   end
   // One frame; afterwards the lines show the inverse, never stale data
   task automatic frame(input logic [7:0] d, input logic fe,
                        input logic pe = 1'b0);
      @(posedge pclk);
      rx_done <= 1'b1;
      rx_data <= d;
      rx_frame_err <= fe;
      rx_parity_err <= pe;
      @(posedge pclk);
      rx_done <= 1'b0;
      rx_data <= ~d;
      rx_frame_err <= ~fe;
      rx_parity_err <= ~pe;
   endtask : frame
endmodule : ssf_shift_model

// ### verif/tb.sv
// Self-checking bench of the serial status block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] STA = ssf_pkg::OFS_STATUS;
   localparam logic [7:0] CTL = ssf_pkg::OFS_CONTROL;
   localparam logic [7:0] TXA = ssf_pkg::OFS_TX_DATA;
   localparam logic [7:0] RXA = ssf_pkg::OFS_RX_DATA;
   localparam logic [7:0] IST = ssf_pkg::OFS_IRQ_STAT;
   localparam logic [7:0] IMK = ssf_pkg::OFS_IRQ_MASK;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        standby = 0, sync_mode = 0, pready, pslverr, e, irq;
   logic [7:0]  paddr = 8'h00, tx_data, rx_data, b, c;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        tx_valid, tx_take, tx_shift_idle, rx_suspend;
   logic        rx_done, rx_frame_err, rx_parity_err;
   int          err_total = 0, comparisons = 0, cyc = 0;
   always #10 pclk = ~pclk;
   ssf_serial_status uut (.*);
   ssf_shift_model u_peer (.*);
   // Expected top three status bits
   function automatic logic [31:0] f(logic t, logic r, logic o);
      return {24'h0, t, r, o, 5'h0};
   endfunction : f
   task automatic chk(input string n, input logic [31:0] s, x);
      comparisons++;
      if (s !== x) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic wrap_up();
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // One APB transfer; an idle edge first keeps back-to-back calls clean
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic st(input logic [31:0] x);
      apb(1'b0, STA, 0);
      chk("status", q & 32'he0, x);
   endtask : st
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(40));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STA, 0);
      chk("status reset", q, 32'h84);
      apb(1'b1, STA, 32'hff);
      st(f(1, 0, 0));
      apb(1'b1, STA, 0);
      st(f(1, 0, 0));
      apb(1'b1, CTL, 32'h30);
      for (int i = 0; i < 3; i++) begin
         b = $urandom;
         u_peer.lat = 8 + $urandom_range(3);
         apb(1'b1, TXA, b);
         st(f(0, 0, 0));
         while (u_peer.sent.size() <= i) @(posedge pclk);
         chk("tx byte", u_peer.sent[i], b);
         st(f(1, 0, 0));
      end
      b = $urandom;
      c = $urandom;
      u_peer.frame(b, 1'b0);
      st(f(1, 1, 0));
      u_peer.frame(c, 1'b0, 1'b1);
      st(f(1, 1, 0));
      u_peer.frame(c, 1'b1);
      apb(1'b0, RXA, 0);
      chk("rx data", q, b);
      st(f(1, 0, 0));
      apb(1'b1, STA, 32'h80);
      u_peer.frame(b, 1'b0);
      u_peer.frame(c, 1'b0);
      st(f(1, 1, 1));
      chk("suspend", rx_suspend, 1'b1);
      apb(1'b0, RXA, 0);
      chk("rx data", q, b);
      u_peer.frame(c, 1'b0);
      st(f(1, 0, 1));
      sync_mode <= 1'b1;
      apb(1'b1, TXA, c);
      @(negedge pclk);
      chk("tx valid", tx_valid, 1'b0);
      apb(1'b1, CTL, 32'h20);
      st(f(0, 0, 1));
      apb(1'b1, STA, 32'h80);
      while (u_peer.sent.size() < 4) @(posedge pclk);
      chk("tx byte", u_peer.sent[3], c);
      st(f(1, 0, 0));
      sync_mode <= 1'b0;
      u_peer.frame(b, 1'b0);
      st(f(1, 0, 0));
      apb(1'b1, CTL, 32'h30);
      u_peer.frame(b, 1'b0);
      apb(1'b1, STA, 32'h80);
      st(f(1, 1, 0));
      apb(1'b1, STA, 32'h80);
      st(f(1, 0, 0));
      apb(1'b1, IMK, 32'h40);
      apb(1'b1, IST, 32'hf8);
      @(negedge pclk);
      chk("irq idle", irq, 1'b0);
      u_peer.frame(c, 1'b0);
      @(negedge pclk);
      chk("irq raised", irq, 1'b1);
      apb(1'b1, IMK, 0);
      @(negedge pclk);
      chk("irq masked", irq, 1'b0);
      apb(1'b1, IMK, 32'h40);
      apb(1'b1, IST, 32'h40);
      @(negedge pclk);
      chk("irq cleared", irq, 1'b0);
      apb(1'b0, 8'h20, 0);
      chk("slverr", e, 1'b1);
      apb(1'b1, TXA, b);
      apb(1'b1, CTL, 32'h10);
      st(f(1, 1, 0));
      chk("tx count", u_peer.sent.size(), 4);
      standby <= 1'b1;
      repeat (2) @(posedge pclk);
      standby <= 1'b0;
      apb(1'b0, STA, 0);
      chk("status standby", q, 32'h84);
      apb(1'b0, CTL, 0);
      chk("control standby", q, 32'h0);
      wrap_up();
   end
endmodule : tb
